// >>> src/csb_pkg.sv
// constants, types and operation codes for the compare, skip and branch unit
// Function
// - compare: dst minus src, result dropped, sets Z N V C H, one cycle
// - compare with carry: dst minus src minus C, sets Z N V C H, one cycle
// - immediate compare: dst minus constant, sets Z N V C H, one cycle
// - skip on register bit clear adds 2 or 3 to pc, 1/2/3 cycles
// - skip on register bit set adds 2 or 3 to pc, 1/2/3 cycles
// - skip on io bit clear adds 2 or 3 to pc, 1/2/3 cycles
// - skip on io bit set adds 2 or 3 to pc, 1/2/3 cycles
// - branch on selected flag set loads pc plus offset plus one, 1/2 cycles
// - branch on selected flag clear loads pc plus offset plus one, 1/2 cycles
// - branch if equal takes branch when zero flag is one, 1/2 cycles
// - branch if not equal takes branch when zero flag is zero, 1/2 cycles
// - skips and branches leave every status flag unchanged
package csb_pkg;
   localparam int PC_W     = 16;
   localparam int OFS_W    = 7;
   localparam int DATA_W   = 8;
   localparam int FLAG_C   = 0;
   localparam int FLAG_Z   = 1;
   localparam int FLAG_N   = 2;
   localparam int FLAG_V   = 3;
   localparam int FLAG_S   = 4;
   localparam int FLAG_H   = 5;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 16'h0000;
   localparam logic [PC_W-1:0] PC_STEP1 = 16'h0001;
   localparam logic [PC_W-1:0] PC_STEP2 = 16'h0002;
   localparam logic [PC_W-1:0] PC_STEP3 = 16'h0003;
   localparam logic [1:0] CYC_1 = 2'h1;
   localparam logic [1:0] CYC_2 = 2'h2;
   localparam logic [1:0] CYC_3 = 2'h3;

   typedef enum logic [3:0] {
      CSB_OP_NONE          = 4'h0,
      CSB_OP_COMPARE       = 4'h1,
      CSB_OP_COMPARE_CARRY = 4'h2,
      CSB_OP_COMPARE_IMM   = 4'h3,
      CSB_OP_SKIP_REG_CLR  = 4'h4,
      CSB_OP_SKIP_REG_SET  = 4'h5,
      CSB_OP_SKIP_IO_CLR   = 4'h6,
      CSB_OP_SKIP_IO_SET   = 4'h7,
      CSB_OP_BRANCH_SET    = 4'h8,
      CSB_OP_BRANCH_CLR    = 4'h9,
      CSB_OP_BRANCH_EQ     = 4'hA,
      CSB_OP_BRANCH_NE     = 4'hB
   } csb_op_e;

   // one decoded instruction as handed in by the fetch stage
   typedef struct packed {
      csb_op_e           op;
      logic [DATA_W-1:0] dst;     // destination register value
      logic [DATA_W-1:0] src;     // source register or immediate
      logic [DATA_W-1:0] io_val;  // addressed io register value
      logic [2:0]        bit_sel; // bit or flag select
      logic [OFS_W-1:0]  offset;  // signed branch offset
      logic              next_two_words; // skipped instruction length
   } csb_instr_s;

   // answer for one retired instruction
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [7:0]      flags;
      logic [1:0]      cycles;
      logic            taken;
   } csb_result_s;

   typedef enum logic [2:0] {
      CSB_ST_IDLE = 3'b001,
      CSB_ST_BUSY = 3'b010,
      CSB_ST_DONE = 3'b100
   } csb_state_e;
endpackage

// >>> src/csb_sub_flags.sv
// subtractor producing compare flags without a stored result
`timescale 1ns/100ps
`default_nettype none
module csb_sub_flags #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] a_in,
   input  wire logic [W-1:0] b_in,
   input  wire logic         carry_in,
   input  wire logic         use_z_in,
   input  wire logic         old_z_in,
   output logic       [7:0]  flags_out
);
   logic [W:0]   diff;
   logic [4:0]   half;
   logic         v;
   logic         n;
   logic         z;

   // the half-borrow needs at least a full nibble plus one bit
   if (W < 5) begin : g_width_check
      $error("csb_sub_flags width too small");
   end

   // difference, half-borrow and flag composition
   always_comb begin
      diff = {1'b0, a_in} - {1'b0, b_in} - {{W{1'b0}}, carry_in};
      half = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, carry_in};
      n    = diff[W-1];
      v    = (a_in[W-1] & ~b_in[W-1] & ~diff[W-1])
           | (~a_in[W-1] & b_in[W-1] & diff[W-1]);
      z    = (diff[W-1:0] == '0) & (~use_z_in | old_z_in); // z can only clear
      flags_out = 8'h00;
      flags_out[csb_pkg::FLAG_C] = diff[W];
      flags_out[csb_pkg::FLAG_Z] = z;
      flags_out[csb_pkg::FLAG_N] = n;
      flags_out[csb_pkg::FLAG_V] = v;
      flags_out[csb_pkg::FLAG_S] = n ^ v;
      flags_out[csb_pkg::FLAG_H] = half[4];
   end
endmodule
`default_nettype wire

// >>> src/csb_unit.sv
// compare, skip and conditional branch execution unit
`timescale 1ns/100ps
`default_nettype none
module csb_unit #(
   parameter int PC_W  = csb_pkg::PC_W,
   parameter int OFS_W = csb_pkg::OFS_W
) (
   input  wire logic                 mclk_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 start_in,
   input  wire csb_pkg::csb_instr_s  instr_in,
   input  wire logic [PC_W-1:0]      pc_in,
   input  wire logic [7:0]           flags_in,
   output logic                      busy_out,
   output logic                      done_out,
   output csb_pkg::csb_result_s      result_out
);
   csb_pkg::csb_state_e  state;
   csb_pkg::csb_state_e  next_state;
   csb_pkg::csb_result_s res;
   csb_pkg::csb_result_s next_res;
   logic [1:0]           wait_cnt;
   logic [1:0]           next_wait_cnt;
   logic [7:0]           cmp_flags;
   logic                 carry_form;
   logic                 sel_bit;
   logic                 cond;
   logic [1:0]           cyc;
   logic [PC_W-1:0]      target;
   logic [PC_W-1:0]      ofs_ext;

   // the carrier structs fix both widths, so only the package values fit
   if (PC_W != csb_pkg::PC_W || OFS_W != csb_pkg::OFS_W
       || OFS_W >= PC_W) begin : g_param_check
      $error("csb_unit parameters out of range");
   end

   assign carry_form = (instr_in.op == csb_pkg::CSB_OP_COMPARE_CARRY);

   // shared subtractor for all three compare forms
   csb_sub_flags #(.W(csb_pkg::DATA_W)) u_sub (
      .a_in      (instr_in.dst),
      .b_in      (instr_in.src),
      .carry_in  (carry_form & flags_in[csb_pkg::FLAG_C]),
      .use_z_in  (carry_form),
      .old_z_in  (flags_in[csb_pkg::FLAG_Z]),
      .flags_out (cmp_flags)
   );

   // condition, target and cycle count of the instruction at the input
   always_comb begin
      ofs_ext = {{(PC_W-OFS_W){instr_in.offset[OFS_W-1]}},
                 instr_in.offset};
      sel_bit = 1'b0;
      cond    = 1'b0;
      target  = pc_in + csb_pkg::PC_STEP1;
      cyc     = csb_pkg::CYC_1;
      case (instr_in.op)
         csb_pkg::CSB_OP_SKIP_REG_CLR, csb_pkg::CSB_OP_SKIP_REG_SET: begin
            sel_bit = instr_in.dst[instr_in.bit_sel];
         end
         csb_pkg::CSB_OP_SKIP_IO_CLR, csb_pkg::CSB_OP_SKIP_IO_SET: begin
            sel_bit = instr_in.io_val[instr_in.bit_sel];
         end
         csb_pkg::CSB_OP_BRANCH_SET, csb_pkg::CSB_OP_BRANCH_CLR: begin
            sel_bit = flags_in[instr_in.bit_sel];
         end
         csb_pkg::CSB_OP_BRANCH_EQ, csb_pkg::CSB_OP_BRANCH_NE: begin
            sel_bit = flags_in[csb_pkg::FLAG_Z];
         end
         default: begin
            sel_bit = 1'b0;
         end
      endcase
      case (instr_in.op)
         csb_pkg::CSB_OP_SKIP_REG_CLR: cond = ~sel_bit;
         csb_pkg::CSB_OP_SKIP_REG_SET: cond = sel_bit;
         csb_pkg::CSB_OP_SKIP_IO_CLR:  cond = ~sel_bit;
         csb_pkg::CSB_OP_SKIP_IO_SET:  cond = sel_bit;
         csb_pkg::CSB_OP_BRANCH_SET:   cond = sel_bit;
         csb_pkg::CSB_OP_BRANCH_CLR:   cond = ~sel_bit;
         csb_pkg::CSB_OP_BRANCH_EQ:    cond = sel_bit;
         csb_pkg::CSB_OP_BRANCH_NE:    cond = ~sel_bit;
         default:                      cond = 1'b0;
      endcase
      if (instr_in.op inside {csb_pkg::CSB_OP_SKIP_REG_CLR,
                              csb_pkg::CSB_OP_SKIP_REG_SET,
                              csb_pkg::CSB_OP_SKIP_IO_CLR,
                              csb_pkg::CSB_OP_SKIP_IO_SET} && cond) begin
         // skip over a one- or two-word instruction
         if (instr_in.next_two_words) begin
            target = pc_in + csb_pkg::PC_STEP3;
            cyc    = csb_pkg::CYC_3;
         end else begin
            target = pc_in + csb_pkg::PC_STEP2;
            cyc    = csb_pkg::CYC_2;
         end
      end else if (instr_in.op inside {csb_pkg::CSB_OP_BRANCH_SET,
                                       csb_pkg::CSB_OP_BRANCH_CLR,
                                       csb_pkg::CSB_OP_BRANCH_EQ,
                                       csb_pkg::CSB_OP_BRANCH_NE}
                   && cond) begin
         target = pc_in + ofs_ext + csb_pkg::PC_STEP1;
         cyc    = csb_pkg::CYC_2;
      end
   end

   // sequencer: accept, hold for the cycle count, then report
   always_comb begin
      next_state    = state;
      next_res      = res;
      next_wait_cnt = wait_cnt;
      case (state)
         csb_pkg::CSB_ST_IDLE, csb_pkg::CSB_ST_DONE: begin
            next_state = csb_pkg::CSB_ST_IDLE;
            if (start_in && instr_in.op != csb_pkg::CSB_OP_NONE) begin
               next_res.pc     = target;
               next_res.cycles = cyc;
               next_res.taken  = cond;
               next_res.flags  = flags_in;
               if (instr_in.op inside {csb_pkg::CSB_OP_COMPARE,
                                       csb_pkg::CSB_OP_COMPARE_CARRY,
                                       csb_pkg::CSB_OP_COMPARE_IMM})
               begin
                  // keep other bits, replace Z N V S C H
                  next_res.flags = (flags_in & 8'hC0)
                                 | (cmp_flags & 8'h3F);
               end
               next_wait_cnt = cyc - csb_pkg::CYC_1;
               next_state    = (cyc == csb_pkg::CYC_1) ?
                               csb_pkg::CSB_ST_DONE : csb_pkg::CSB_ST_BUSY;
            end
         end
         csb_pkg::CSB_ST_BUSY: begin
            next_wait_cnt = wait_cnt - csb_pkg::CYC_1;
            if (wait_cnt == csb_pkg::CYC_1) begin
               next_state = csb_pkg::CSB_ST_DONE;
            end
         end
         default: begin
            next_state = csb_pkg::CSB_ST_IDLE;
         end
      endcase
   end

   // state registers
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state    <= csb_pkg::CSB_ST_IDLE;
         res      <= '{pc: csb_pkg::PC_RST, flags: csb_pkg::FLAGS_RST,
                       cycles: 2'h0, taken: 1'b0};
         wait_cnt <= 2'h0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         state    <= next_state;
         res      <= next_res;
         wait_cnt <= next_wait_cnt;
         busy_out <= (next_state == csb_pkg::CSB_ST_BUSY);
         done_out <= (next_state == csb_pkg::CSB_ST_DONE);
      end
   end

   assign result_out = res;

   // compare always reports one cycle
   property p_cmp_one;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (state != csb_pkg::CSB_ST_BUSY && start_in &&
       instr_in.op == csb_pkg::CSB_OP_COMPARE)
      |=> done_out && res.cycles == 2'h1;
   endproperty
   a_cmp_one: assert property (p_cmp_one)
      else $error("compare not 1 cycle");

   property p_cpc_carry;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (state != csb_pkg::CSB_ST_BUSY && start_in &&
       instr_in.op == csb_pkg::CSB_OP_COMPARE_CARRY &&
       instr_in.dst == instr_in.src && flags_in[csb_pkg::FLAG_C])
      |=> res.flags[csb_pkg::FLAG_C] && !res.flags[csb_pkg::FLAG_Z];
   endproperty
   a_cpc_carry: assert property (p_cpc_carry)
      else $error("carry ignored");

   property p_cpi_zero;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (state != csb_pkg::CSB_ST_BUSY && start_in &&
       instr_in.op == csb_pkg::CSB_OP_COMPARE_IMM)
      |=> res.flags[csb_pkg::FLAG_Z] == ($past(instr_in.dst) ==
                                         $past(instr_in.src));
   endproperty
   a_cpi_zero: assert property (p_cpi_zero)
      else $error("imm zero wrong");

   property p_skip_len;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (state != csb_pkg::CSB_ST_BUSY && start_in &&
       instr_in.op == csb_pkg::CSB_OP_SKIP_REG_CLR &&
       !instr_in.dst[instr_in.bit_sel] && instr_in.next_two_words)
      |=> busy_out ##1 busy_out ##1 done_out
          && res.pc == $past(pc_in, 3) + csb_pkg::PC_STEP3;
   endproperty
   a_skip_len: assert property (p_skip_len)
      else $error("skip 3 wrong");

   property p_skip_set;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (state != csb_pkg::CSB_ST_BUSY && start_in &&
       instr_in.op == csb_pkg::CSB_OP_SKIP_REG_SET &&
       !instr_in.dst[instr_in.bit_sel])
      |=> done_out && res.pc == $past(pc_in) + csb_pkg::PC_STEP1;
   endproperty
   a_skip_set: assert property (p_skip_set)
      else $error("skip set wrong");

   property p_io_clr;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (state != csb_pkg::CSB_ST_BUSY && start_in &&
       instr_in.op == csb_pkg::CSB_OP_SKIP_IO_CLR &&
       !instr_in.io_val[instr_in.bit_sel] && !instr_in.next_two_words)
      |=> busy_out ##1 done_out && res.cycles == 2'h2;
   endproperty
   a_io_clr: assert property (p_io_clr)
      else $error("io skip wrong");

   property p_br_eq;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (state != csb_pkg::CSB_ST_BUSY && start_in &&
       instr_in.op == csb_pkg::CSB_OP_BRANCH_EQ)
      |=> res.taken == $past(flags_in[csb_pkg::FLAG_Z]);
   endproperty
   a_br_eq: assert property (p_br_eq)
      else $error("beq wrong");

   property p_br_flags;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (state != csb_pkg::CSB_ST_BUSY && start_in &&
       instr_in.op inside {csb_pkg::CSB_OP_BRANCH_SET,
                           csb_pkg::CSB_OP_BRANCH_NE,
                           csb_pkg::CSB_OP_SKIP_IO_SET})
      |=> res.flags == $past(flags_in);
   endproperty
   a_br_flags: assert property (p_br_flags)
      else $error("flags changed");
endmodule
`default_nettype wire

// >>> test/csb_fetch_model.sv
// fetch stage and register file model feeding the execution unit
`timescale 1ns/100ps
`default_nettype none
module csb_fetch_model (
   input  wire logic                mclk_in,
   input  wire logic                busy_in,
   input  wire logic                done_in,
   input  wire logic                spam_in,
   output var  logic                start_out,
   output var  csb_pkg::csb_instr_s instr_out,
   output var  logic [15:0]         pc_out,
   output var  logic [7:0]          flags_out
);
   // quiet bus at time zero
   initial begin
      start_out = 1'b0;
      instr_out = '0;
      pc_out = 16'h0000;
      flags_out = 8'h00;
   end

   // wait out a busy unit, optionally pestering it, then hand one over
   task automatic issue(input csb_pkg::csb_instr_s i, input logic [15:0] pc,
                        input logic [7:0] fl);
      while (busy_in === 1'b1 && done_in !== 1'b1) begin
         start_out = spam_in;
         instr_out.op = csb_pkg::CSB_OP_COMPARE_IMM; // must be ignored
         @(posedge mclk_in);
         #2;
      end
      start_out = 1'b1;
      instr_out = i;
      pc_out = pc;
      flags_out = fl;
      @(posedge mclk_in);
      #2;
   endtask

   // drop the request line
   task automatic idle();
      start_out = 1'b0;
      @(posedge mclk_in);
      #2;
   endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the compare, skip and branch unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct {
      csb_pkg::csb_result_s r;
      logic [3:0]           op;
      int                   due;
   } csb_note_s;
   logic                 mclk_in;
   logic                 rst_n_in;
   logic                 start_in;
   logic                 spam;
   csb_pkg::csb_instr_s  instr_in;
   logic [15:0]          pc_in;
   logic [7:0]           flags_in;
   logic                 busy_out;
   logic                 done_out;
   csb_pkg::csb_result_s result_out;
   int                   mismatches;
   int                   checks_done;
   int                   cyc;
   int                   busy_cnt;
   integer               seed;
   logic [31:0]          w0;
   logic [31:0]          w1;
   csb_note_s            exp_q[$];
   csb_note_s            n;

   csb_unit dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .start_in(start_in), .instr_in(instr_in), .pc_in(pc_in),
      .flags_in(flags_in), .busy_out(busy_out), .done_out(done_out),
      .result_out(result_out));
   csb_fetch_model fetch_u (.mclk_in(mclk_in), .busy_in(busy_out),
      .done_in(done_out), .spam_in(spam), .start_out(start_in),
      .instr_out(instr_in), .pc_out(pc_in), .flags_out(flags_in));

   // clock and cycle count
   always #10 mclk_in = ~mclk_in;
   always @(posedge mclk_in) cyc = cyc + 1;

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // expected answer; op bit 0 picks set or clear, bit 1 io or equal forms
   function automatic csb_pkg::csb_result_s expect_of(
      csb_pkg::csb_instr_s i, logic [15:0] pc, logic [7:0] f);
      csb_pkg::csb_result_s r;
      logic [8:0]           d;
      logic                 c;
      logic                 t;
      r = '{pc: pc + 16'h0001, flags: f, cycles: 2'h1, taken: 1'b0};
      if (i.op < csb_pkg::CSB_OP_SKIP_REG_CLR) begin
         c = (i.op == csb_pkg::CSB_OP_COMPARE_CARRY);
         d = {1'b0, i.dst} - {1'b0, i.src} - {8'h00, c & f[0]};
         r.flags[0] = d[8];
         r.flags[1] = (d[7:0] == 8'h00) & (~c | f[1]);
         r.flags[2] = d[7];
         r.flags[3] = (i.dst[7] & ~i.src[7] & ~d[7]) |
                      (~i.dst[7] & i.src[7] & d[7]);
         r.flags[4] = r.flags[2] ^ r.flags[3];
         r.flags[5] = (~i.dst[3] & i.src[3]) | (i.src[3] & d[3]) |
                      (d[3] & ~i.dst[3]);
      end else if (i.op < csb_pkg::CSB_OP_BRANCH_SET) begin
         t = (i.op[1] ? i.io_val[i.bit_sel] : i.dst[i.bit_sel]) == i.op[0];
         r.taken = t;
         if (t) begin
            r.pc = pc + (i.next_two_words ? 16'h0003 : 16'h0002);
            r.cycles = i.next_two_words ? 2'h3 : 2'h2;
         end
      end else begin
         t = (i.op[1] ? f[1] : f[i.bit_sel]) == ~i.op[0];
         r.taken = t;
         if (t) begin
            r.pc = pc + {{9{i.offset[6]}}, i.offset} + 16'h0001;
            r.cycles = 2'h2;
         end
      end
      return r;
   endfunction

   // issue one instruction and note what should come back
   task automatic run(input csb_pkg::csb_op_e op, input logic [7:0] d,
                      input logic [7:0] s, input logic [2:0] bs,
                      input logic [6:0] ofs, input logic tw,
                      input logic [7:0] fl, input logic [15:0] pc);
      csb_pkg::csb_instr_s i;
      csb_note_s           e;
      i = '{op, d, s, s, bs, ofs, tw};
      if (op inside {csb_pkg::CSB_OP_SKIP_REG_CLR,
                     csb_pkg::CSB_OP_SKIP_REG_SET})
         i.src = d; // either operand reading sees the same bit
      fetch_u.issue(i, pc, fl);
      if (op != csb_pkg::CSB_OP_NONE) begin
         e.r = expect_of(i, pc, fl);
         e.op = op;
         // done shows cycles-1 edges after the accepting edge
         e.due = cyc + int'(e.r.cycles) - 1;
         exp_q.push_back(e);
      end
   endtask

   // compare each finished instruction with the oldest note, mid-cycle
   always @(negedge mclk_in) begin
      if (done_out === 1'b1 && exp_q.size() == 0)
         check("spare done", 32'h1, 32'h0);
      else if (done_out === 1'b1) begin
         n = exp_q.pop_front();
         check("pc", 32'(result_out.pc), 32'(n.r.pc));
         check("flags", 32'(result_out.flags), 32'(n.r.flags));
         check("cycles", 32'(result_out.cycles), 32'(n.r.cycles));
         check("done time", cyc, n.due);
         check("busy span", busy_cnt, int'(n.r.cycles) - 1);
         if (n.op >= 4'h4)
            check("taken", 32'(result_out.taken), 32'(n.r.taken));
         busy_cnt = 0;
      end
      if (busy_out === 1'b1)
         busy_cnt++;
   end

   // main sequence: reset, corner cases, then random traffic
   initial begin
      mclk_in = 1'b0;
      rst_n_in = 1'b0;
      spam = 1'b0;
      mismatches = 0;
      checks_done = 0;
      cyc = 0;
      busy_cnt = 0;
      seed = 32'hEB454536;
      repeat (16) @(posedge mclk_in);
      #2;
      check("reset", 32'({busy_out, done_out, result_out}), 32'h0);
      rst_n_in = 1'b1;
      @(posedge mclk_in);
      #2;
      run(csb_pkg::CSB_OP_COMPARE_CARRY, 8'h56, 8'h55, 3'h0, 7'h00, 1'b0,
          8'h03, 16'h0100);
      run(csb_pkg::CSB_OP_COMPARE_CARRY, 8'h56, 8'h55, 3'h0, 7'h00, 1'b0,
          8'h01, 16'h0100);
      run(csb_pkg::CSB_OP_COMPARE, 8'h80, 8'h01, 3'h0, 7'h00, 1'b0,
          8'h00, 16'h0200);
      run(csb_pkg::CSB_OP_COMPARE_IMM, 8'h10, 8'h01, 3'h0, 7'h00, 1'b0,
          8'hC0, 16'h0300);
      run(csb_pkg::CSB_OP_SKIP_IO_SET, 8'h00, 8'h80, 3'h7, 7'h00, 1'b1,
          8'h3F, 16'h0400);
      run(csb_pkg::CSB_OP_SKIP_REG_CLR, 8'hFE, 8'h00, 3'h0, 7'h00, 1'b0,
          8'h00, 16'h0500);
      run(csb_pkg::CSB_OP_BRANCH_EQ, 8'h00, 8'h00, 3'h0, 7'h40, 1'b0,
          8'h02, 16'h0010);
      run(csb_pkg::CSB_OP_BRANCH_NE, 8'h00, 8'h00, 3'h0, 7'h3F, 1'b0,
          8'h00, 16'hFFF0);
      run(csb_pkg::CSB_OP_BRANCH_SET, 8'h00, 8'h00, 3'h7, 7'h01, 1'b0,
          8'h80, 16'h0600);
      run(csb_pkg::CSB_OP_BRANCH_CLR, 8'h00, 8'h00, 3'h0, 7'h7F, 1'b0,
          8'hFE, 16'h0700);
      for (int k = 0; k < 300; k++) begin
         w0 = $random(seed);
         w1 = $random(seed);
         spam = w0[27];
         run(csb_pkg::csb_op_e'(w0[31:28] % 4'hC), w0[7:0], w0[15:8],
             w0[26:24], w1[6:0], w1[7], w1[15:8], w1[31:16]);
      end
      fetch_u.idle();
      repeat (5) @(posedge mclk_in);
      check("notes left", 32'(exp_q.size()), 32'h0);
      wrap_up();
   end

   // watchdog against a hung handshake
   initial begin
      #(20 * 5000);
      mismatches++;
      wrap_up();
   end
endmodule
`default_nettype wire
